// *** rtl/irq_ctrl.sv ***
// Interrupt enable and flag control with return stack.
// Assumes event pulses and core strobes are synchronous to clk.
`timescale 1ns/10ps
module irq_ctrl
    import irq_ctrl_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rdata,
    input wire logic timer_overflow,
    input wire logic external_irq_pin,
    input wire logic monitored_pin_a,
    input wire logic monitored_pin_b,
    input wire logic monitored_pin_c,
    input wire logic pin_c_is_master_clear,
    input wire logic [7:0] periph_events,
    input wire logic [PC_WIDTH-1:0] program_counter,
    input wire logic irq_ack,
    input wire logic return_from_interrupt,
    output logic core_irq,
    output logic [PC_WIDTH-1:0] return_address,
    output logic irq
);
    logic [7:0] interrupt_control_reg;
    logic [7:0] peripheral_interrupt_flags_reg;
    logic [7:0] peripheral_interrupt_enables_reg;
    logic external_edge_select_reg;
    logic [2:0] irq_status_reg;
    logic [2:0] irq_enable_reg;
    logic [7:0] rdata_reg;
    logic ext_pin_reg;
    logic [2:0] pins_reg;
    logic [PC_WIDTH-1:0] return_address_reg;
    logic [2:0] pins_now;
    logic wr_control;
    logic ext_edge;
    logic pin_change;
    logic core_pending;
    logic periph_pending;
    logic push;
    logic [PC_WIDTH-1:0] stack_top;
    logic [2:0] events;

    // ****************************************
    // Decode
    // ****************************************
    assign wr_control = wr_en &&
        (addr == ADDR_CONTROL_LO || addr == ADDR_CONTROL_HI); // [RQ1]

    // ****************************************
    // Event detection
    // ****************************************
    assign pins_now = {monitored_pin_c & ~pin_c_is_master_clear,
                       monitored_pin_b, monitored_pin_a};

    // Pins tracked through reset so its release shows no false edge
    always_ff @(posedge clk) begin
        ext_pin_reg <= external_irq_pin;
        pins_reg <= pins_now;
    end

    assign ext_edge = external_edge_select_reg ?
        (external_irq_pin & ~ext_pin_reg) :
        (~external_irq_pin & ext_pin_reg); // [RQ15]
    assign pin_change = |(pins_now ^ pins_reg); // [RQ16]

    // ****************************************
    // Control register
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            interrupt_control_reg <= CONTROL_RESET;
        end else begin
            if (wr_control) begin
                interrupt_control_reg <= wdata; // [RQ1]
            end
            if (push) begin
                interrupt_control_reg[BIT_GLOBAL_EN] <= 1'b0;
            end else if (return_from_interrupt) begin
                interrupt_control_reg[BIT_GLOBAL_EN] <= 1'b1;
            end
            // Hardware set wins over a software clear
            if (timer_overflow) begin
                interrupt_control_reg[BIT_TIMER_FLAG] <= 1'b1; // [RQ7] [RQ10]
            end
            if (ext_edge) begin
                interrupt_control_reg[BIT_EXT_FLAG] <= 1'b1; // [RQ8] [RQ10]
            end
            if (pin_change) begin
                interrupt_control_reg[BIT_CHG_FLAG] <= 1'b1; // [RQ9] [RQ10]
            end
        end
    end

    // ****************************************
    // Peripheral registers
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            peripheral_interrupt_flags_reg <= PERIPH_RESET;
        end else begin
            peripheral_interrupt_flags_reg <=
                ((wr_en && addr == ADDR_PERIPH_FLAGS) ?
                 wdata : peripheral_interrupt_flags_reg)
                | periph_events; // [RQ10] [RQ11]
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            peripheral_interrupt_enables_reg <= PERIPH_RESET;
        end else if (wr_en && addr == ADDR_PERIPH_ENABLES) begin
            peripheral_interrupt_enables_reg <= wdata; // [RQ11]
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            external_edge_select_reg <= EDGE_SEL_RESET[BIT_EDGE_SEL];
        end else if (wr_en && addr == ADDR_EDGE_SELECT) begin
            external_edge_select_reg <= wdata[BIT_EDGE_SEL]; // [RQ15]
        end
    end

    // ****************************************
    // Request to the core
    // ****************************************
    assign core_pending =
        (interrupt_control_reg[BIT_TIMER_EN] &
         interrupt_control_reg[BIT_TIMER_FLAG]) | // [RQ4]
        (interrupt_control_reg[BIT_EXT_EN] &
         interrupt_control_reg[BIT_EXT_FLAG]) | // [RQ5]
        (interrupt_control_reg[BIT_CHG_EN] &
         interrupt_control_reg[BIT_CHG_FLAG]); // [RQ6]
    assign periph_pending = interrupt_control_reg[BIT_GROUP_EN] &
        |(peripheral_interrupt_enables_reg &
          peripheral_interrupt_flags_reg); // [RQ3]
    assign core_irq = interrupt_control_reg[BIT_GLOBAL_EN] &
        (core_pending | periph_pending); // [RQ2] [RQ17]
    assign push = irq_ack & core_irq; // [RQ13]

    // ****************************************
    // Return stack
    // ****************************************
    return_stack u_stack (
        .clk(clk),
        .rst_b(rst_b),
        .push(push),
        .pop(return_from_interrupt & ~push),
        .push_data(program_counter),
        .top_data(stack_top)
    );

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            return_address_reg <= '0;
        end else if (return_from_interrupt & ~push) begin
            return_address_reg <= stack_top; // [RQ14]
        end
    end
    assign return_address = return_address_reg;

    // ****************************************
    // Block interrupt status
    // ****************************************
    assign events = {(core_pending | periph_pending) &
                     ~interrupt_control_reg[BIT_GLOBAL_EN],
                     return_from_interrupt & ~push, push};

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            irq_status_reg <= STATUS_RESET[2:0];
        end else begin
            irq_status_reg <= (wr_en && addr == ADDR_IRQ_CLEAR) ?
                ((irq_status_reg & ~wdata[2:0]) | events) :
                (irq_status_reg | events);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            irq_enable_reg <= STATUS_RESET[2:0];
        end else if (wr_en && addr == ADDR_IRQ_ENABLE) begin
            irq_enable_reg <= wdata[2:0];
        end
    end
    assign irq = |(irq_status_reg & irq_enable_reg);

    // ****************************************
    // Read data
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rdata_reg <= 8'h00;
        end else if (rd_en) begin
            unique case (addr)
                ADDR_CONTROL_LO, ADDR_CONTROL_HI:
                    rdata_reg <= interrupt_control_reg; // [RQ1]
                ADDR_PERIPH_FLAGS: rdata_reg <= peripheral_interrupt_flags_reg;
                ADDR_PERIPH_ENABLES:
                    rdata_reg <= peripheral_interrupt_enables_reg;
                ADDR_EDGE_SELECT:
                    rdata_reg <= {1'b0, external_edge_select_reg, 6'h00};
                ADDR_IRQ_STATUS: rdata_reg <= {5'h00, irq_status_reg};
                ADDR_IRQ_ENABLE: rdata_reg <= {5'h00, irq_enable_reg};
                default: rdata_reg <= 8'h00;
            endcase
        end else begin
            rdata_reg <= 8'h00;
        end
    end
    assign rdata = rdata_reg;
endmodule : irq_ctrl

// *** inc/irq_ctrl_pkg.sv ***
// Constants for the interrupt enable and flag control block.
// Assumes a single core clock and a plain register port.
// Operation
// [RQ1] Control register mirrored at two addresses
// [RQ2] Global enable gates every interrupt
// [RQ3] Peripheral group enable gates peripheral sources
// [RQ4] Timer overflow enable masks timer flag
// [RQ5] External pin enable masks pin flag
// [RQ6] Pin-change enable masks pin-change flag
// [RQ7] Timer overflow sets sticky flag
// [RQ8] Qualifying pin edge sets sticky flag
// [RQ9] Any monitored pin change sets flag
// [RQ10] Flags set regardless of any enable
// [RQ11] Separate peripheral enable and flag registers
// [RQ12] Software clears flag before enabling it
// [RQ13] Interrupt branch pushes 13-bit counter
// [RQ14] Return pops stack, circular, no indication
// [RQ15] Edge select picks rising or falling
// [RQ16] Pin-change covers all three pins together; the code leaves pin c out while pin_c_is_master_clear is set
// [RQ17] Request is gated OR of pairs
package irq_ctrl_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] ADDR_CONTROL_LO = 8'h0b;
    localparam logic [7:0] ADDR_CONTROL_HI = 8'h8b;
    localparam logic [7:0] ADDR_PERIPH_FLAGS = 8'h0c;
    localparam logic [7:0] ADDR_PERIPH_ENABLES = 8'h8c;
    localparam logic [7:0] ADDR_EDGE_SELECT = 8'h81;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h90;
    localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h91;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h92;
    // ****************************************
    // Control register and edge select register fields
    // ****************************************
    localparam int BIT_GLOBAL_EN = 7;
    localparam int BIT_GROUP_EN = 6;
    localparam int BIT_TIMER_EN = 5;
    localparam int BIT_EXT_EN = 4;
    localparam int BIT_CHG_EN = 3;
    localparam int BIT_TIMER_FLAG = 2;
    localparam int BIT_EXT_FLAG = 1;
    localparam int BIT_CHG_FLAG = 0;
    localparam int BIT_EDGE_SEL = 6;
    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] PERIPH_RESET = 8'h00;
    localparam logic [7:0] EDGE_SEL_RESET = 8'h40;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    // ****************************************
    // Sizes
    // ****************************************
    localparam int PC_WIDTH = 13;
    localparam int STACK_DEPTH = 8;
    localparam int STACK_PTR_WIDTH = 3;
    // Status event bits
    localparam int EV_IRQ_TAKEN = 0;
    localparam int EV_IRQ_RETURN = 1;
    localparam int EV_BLOCKED = 2;
endpackage : irq_ctrl_pkg

// *** rtl/return_stack.sv ***
// Circular return stack for the program counter.
// Assumes push and pop never arrive together.
`timescale 1ns/10ps
module return_stack
    import irq_ctrl_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic push,
    input wire logic pop,
    input wire logic [PC_WIDTH-1:0] push_data,
    output logic [PC_WIDTH-1:0] top_data
);
    logic [PC_WIDTH-1:0] stack_mem [STACK_DEPTH];
    logic [STACK_PTR_WIDTH-1:0] ptr_reg;

    // ****************************************
    // Pointer wraps, no overflow indication
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ptr_reg <= '0;
        end else if (push) begin
            ptr_reg <= ptr_reg + 3'h1; // [RQ14]
        end else if (pop) begin
            ptr_reg <= ptr_reg - 3'h1; // [RQ14]
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            stack_mem[ptr_reg] <= push_data; // [RQ13]
        end
    end

    assign top_data = stack_mem[ptr_reg - 3'h1];
endmodule : return_stack

// *** sim/irq_ctrl_assertions.sv ***
// Checker for the interrupt control block.
// Assumes it is bound to irq_ctrl and sees only its ports.
`timescale 1ns/10ps
module irq_ctrl_assertions
    import irq_ctrl_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] addr,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] rdata,
    input wire logic timer_overflow,
    input wire logic monitored_pin_a,
    input wire logic [7:0] periph_events,
    input wire logic irq_ack,
    input wire logic return_from_interrupt,
    input wire logic core_irq,
    input wire logic [PC_WIDTH-1:0] return_address
);
    // ****************************************
    // Properties
    // ****************************************
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence rd_ctl;
        rd_en && addr == ADDR_CONTROL_LO;
    endsequence
    sequence rd_pir;
        rd_en && addr == ADDR_PERIPH_FLAGS;
    endsequence
    chk_rdata_idle: assert property (
        !rd_en |=> rdata == 8'h00) else $error("idle read data");
    chk_unmapped_zero: assert property (
        rd_en && addr == 8'h55 |=> rdata == 8'h00) else $error("unmapped");
    chk_entry_masks: assert property (
        irq_ack && core_irq && !wr_en |=> !core_irq) else $error("entry");
    chk_global_gate: assert property (
        rd_ctl ##0 (!irq_ack && !return_from_interrupt)
        ##1 !rdata[BIT_GLOBAL_EN]
        |-> !core_irq) else $error("request while global off");
    chk_timer_flag: assert property (
        timer_overflow ##1 !wr_en ##1 rd_ctl |=> rdata[BIT_TIMER_FLAG])
        else $error("timer flag");
    chk_change_flag: assert property (
        $changed(monitored_pin_a) ##1 !wr_en ##1 rd_ctl
        |=> rdata[BIT_CHG_FLAG]) else $error("change flag");
    chk_periph_flag: assert property (
        periph_events[0] ##1 (!wr_en)[*3] ##1 rd_pir |=> rdata[0])
        else $error("peripheral flag");
    chk_return_hold: assert property (
        !return_from_interrupt |=> $stable(return_address))
        else $error("return address moved");
    chk_return_global: assert property (
        return_from_interrupt ##1 !wr_en ##1 rd_ctl |=> rdata[BIT_GLOBAL_EN])
        else $error("return global enable");
endmodule : irq_ctrl_assertions

bind irq_ctrl irq_ctrl_assertions u_irq_ctrl_assertions (
    .clk(clk), .rst_b(rst_b), .addr(addr), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .timer_overflow(timer_overflow),
    .monitored_pin_a(monitored_pin_a), .periph_events(periph_events),
    .irq_ack(irq_ack), .return_from_interrupt(return_from_interrupt),
    .core_irq(core_irq), .return_address(return_address));

// *** sim/core_model.sv ***
// Processor core model: takes requests and runs the counter.
// Assumes latency is set by the bench.
`timescale 1ns/10ps
module core_model
    import irq_ctrl_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic core_irq,
    input wire logic [3:0] latency,
    output logic irq_ack,
    output logic [PC_WIDTH-1:0] program_counter
);
    // ****************************************
    // Acknowledge after latency
    // ****************************************
    logic [3:0] wait_reg;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wait_reg <= 4'h0;
            irq_ack <= 1'b0;
            program_counter <= {PC_WIDTH{1'b0}};
        end else begin
            program_counter <= program_counter + 1'b1;
            irq_ack <= 1'b0;
            wait_reg <= 4'h0;
            if (core_irq && !irq_ack && wait_reg == latency) begin
                irq_ack <= 1'b1;
            end else if (core_irq && !irq_ack) begin
                wait_reg <= wait_reg + 4'h1;
            end
        end
    end
endmodule : core_model

// *** sim/irq_ctrl_tb.sv ***
// Testbench for the interrupt control block.
// Assumes the core model answers interrupt requests.
`timescale 1ns/10ps
module irq_ctrl_tb
    import irq_ctrl_pkg::*;
;
    typedef struct packed {
        logic [7:0] ctl;
        logic [7:0] pie;
        logic [4:0] ev;
        logic irq;
        logic [7:0] exp;
    } row_t;
    row_t rows [10] = '{'{8'h20, 8'h00, 5'h01, 1'b0, 8'h24},
        '{8'ha0, 8'h00, 5'h01, 1'b1, 8'ha4}, '{8'h80, 8'h00, 5'h01, 1'b0, 8'h84},
        '{8'h90, 8'h00, 5'h02, 1'b1, 8'h92}, '{8'h90, 8'h00, 5'h02, 1'b0, 8'h90},
        '{8'h88, 8'h00, 5'h04, 1'b1, 8'h89}, '{8'h80, 8'h00, 5'h04, 1'b0, 8'h81},
        '{8'hc0, 8'h01, 5'h08, 1'b1, 8'hc0}, '{8'h80, 8'h01, 5'h08, 1'b0, 8'h80},
        '{8'hc0, 8'h00, 5'h08, 1'b0, 8'hc0}};
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic timer_overflow = 1'b0;
    logic external_irq_pin = 1'b0;
    logic monitored_pin_a = 1'b0;
    logic monitored_pin_b = 1'b0;
    logic monitored_pin_c = 1'b0;
    logic pin_c_is_master_clear = 1'b0;
    logic [7:0] periph_events = 8'h00;
    logic return_from_interrupt = 1'b0;
    logic [3:0] latency = 4'hf;
    logic [7:0] rdata;
    logic irq_ack, core_irq, irq;
    logic [PC_WIDTH-1:0] program_counter, return_address;
    logic [PC_WIDTH-1:0] pcs [9];
    int error_cnt = 0;
    int comparisons = 0;
    int n;
    always #50 clk = ~clk;
    irq_ctrl u_irq_ctrl (.clk(clk), .rst_b(rst_b), .addr(addr),
        .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .timer_overflow(timer_overflow), .external_irq_pin(external_irq_pin),
        .monitored_pin_a(monitored_pin_a), .monitored_pin_b(monitored_pin_b),
        .monitored_pin_c(monitored_pin_c),
        .pin_c_is_master_clear(pin_c_is_master_clear),
        .periph_events(periph_events), .program_counter(program_counter),
        .irq_ack(irq_ack), .return_from_interrupt(return_from_interrupt),
        .core_irq(core_irq), .return_address(return_address), .irq(irq));
    core_model u_core_model (.clk(clk), .rst_b(rst_b), .core_irq(core_irq),
        .latency(latency), .irq_ack(irq_ack),
        .program_counter(program_counter));
    // ****************************************
    // Tasks
    // ****************************************
    task automatic check(input string name, input logic [15:0] seen,
        input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 check("rdata", rdata, exp);
    endtask : rd
    task automatic pulse(input logic [4:0] ev);
        @(posedge clk);
        timer_overflow <= ev[0];
        external_irq_pin <= external_irq_pin ^ ev[1];
        monitored_pin_a <= monitored_pin_a ^ ev[2];
        periph_events <= {7'h00, ev[3]};
        monitored_pin_c <= monitored_pin_c ^ ev[4];
        @(posedge clk);
        timer_overflow <= 1'b0;
        periph_events <= 8'h00;
    endtask : pulse
    task automatic stop_test();
        $display("counts: %0d mismatches, %0d checks", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : stop_test
    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        foreach (rows[i]) begin
            wr(ADDR_PERIPH_FLAGS, 8'h00);
            wr(ADDR_PERIPH_ENABLES, rows[i].pie);
            wr(ADDR_CONTROL_LO, rows[i].ctl);
            pulse(rows[i].ev);
            rd(ADDR_CONTROL_LO, rows[i].exp);
            rd(ADDR_PERIPH_FLAGS, {7'h00, rows[i].ev[3]});
            rd(ADDR_CONTROL_HI, rows[i].exp);
            check("core_irq", core_irq, rows[i].irq);
        end
        $display("done: table");
        wr(ADDR_EDGE_SELECT, 8'h00);
        wr(ADDR_CONTROL_LO, 8'h00);
        pulse(5'h02);
        rd(ADDR_CONTROL_LO, 8'h00);
        pulse(5'h02);
        rd(ADDR_CONTROL_LO, 8'h02);
        wr(ADDR_EDGE_SELECT, 8'h40);
        wr(ADDR_CONTROL_LO, 8'h00);
        pin_c_is_master_clear <= 1'b1;
        pulse(5'h10);
        rd(ADDR_CONTROL_LO, 8'h00);
        @(posedge clk);
        pin_c_is_master_clear <= 1'b0;
        pulse(5'h10);
        rd(ADDR_CONTROL_LO, 8'h01);
        $display("done: edges");
        for (int i = 0; i < 9; i++) begin
            latency <= i[0] ? 4'h5 : 4'h0;
            wr(ADDR_CONTROL_LO, 8'ha0);
            pulse(5'h01);
            for (n = 0; n < 40 && !(irq_ack && core_irq); n++) begin
                @(posedge clk);
                #1;
            end
            if (n == 40) begin
                error_cnt++;
                stop_test();
            end
            pcs[i] = program_counter;
            wr(ADDR_CONTROL_LO, 8'h00);
        end
        for (int i = 8; i > 0; i--) begin
            @(posedge clk);
            return_from_interrupt <= 1'b1;
            @(posedge clk);
            return_from_interrupt <= 1'b0;
            #1 check("return_address", return_address, pcs[i]);
        end
        rd(ADDR_CONTROL_LO, 8'h80);
        $display("done: stack");
        wr(ADDR_IRQ_ENABLE, 8'h03);
        #1 check("irq", irq, 16'h0001);
        rd(ADDR_IRQ_STATUS, 8'h07);
        rd(ADDR_IRQ_ENABLE, 8'h03);
        wr(ADDR_IRQ_CLEAR, 8'h07);
        #1 check("irq", irq, 16'h0000);
        rd(ADDR_IRQ_STATUS, 8'h00);
        rd(ADDR_IRQ_CLEAR, 8'h00);
        rd(8'h55, 8'h00);
        $display("done: status");
        wr(ADDR_PERIPH_ENABLES, 8'hff);
        wr(ADDR_EDGE_SELECT, 8'h00);
        @(posedge clk);
        rst_b <= 1'b0;
        external_irq_pin <= 1'b1;
        monitored_pin_a <= 1'b1;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        rd(ADDR_CONTROL_HI, 8'h00);
        rd(ADDR_PERIPH_ENABLES, 8'h00);
        rd(ADDR_EDGE_SELECT, 8'h40);
        $display("done: reset");
        stop_test();
    end
endmodule : irq_ctrl_tb
